//--- fs_pkg.sv
package fs_pkg;

    // ------------------------------------------------------------------
    // Clock and time base
    // ------------------------------------------------------------------
    localparam int CLK_HZ          = 20_000_000;
    localparam int TICK_MS         = 1;
    localparam int TICK_CYCLES     = CLK_HZ / 1000 * TICK_MS;
    localparam int AUX_RECOVERY_S  = 60;
    localparam int AUX_RECOVERY_MS = AUX_RECOVERY_S * 1000;
    localparam int BLINK_HALF_MS   = 250;
    localparam int NUM_CH          = 2;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam int         ADDR_W      = 4;
    localparam int         DATA_W      = 16;
    localparam logic [3:0] REG_CONFIG  = 4'h0;
    localparam logic [3:0] REG_MONTIME = 4'h1;
    localparam logic [3:0] REG_STATUS  = 4'h2;
    localparam logic [3:0] REG_ACK     = 4'h3;

    // Configuration fields.
    localparam int CFG_EN_LSB    = 0;
    localparam int CFG_WB_LSB    = 2;
    localparam int CFG_RB_LSB    = 4;
    localparam int CFG_RB_STRIDE = 4;
    localparam int CFG_MODE_BIT  = 12;
    localparam int ACK_BIT       = 0;

    // Status fields.
    localparam int ST_CH_PASS_LSB = 0;
    localparam int ST_MOD_PASS    = 2;
    localparam int ST_SHORT_LSB   = 3;
    localparam int ST_DISCH_LSB   = 5;
    localparam int ST_WB_LSB      = 7;
    localparam int ST_SUPPLY      = 9;
    localparam int ST_AUX         = 10;
    localparam int ST_AWAIT       = 11;
    localparam int ST_PARAM       = 12;
    localparam int ST_COMM        = 13;

    // ------------------------------------------------------------------
    // Readback times and monitoring time
    // ------------------------------------------------------------------
    localparam int         RB_CODE_W   = 3;
    localparam logic [2:0] RB_CODE_MAX = 3'h6;
    localparam int         RB_MS_W     = 9;
    localparam logic [8:0] RB_MS_TABLE [0:6] = '{9'h001, 9'h005, 9'h00A, 9'h032,
                                                9'h064, 9'h0C8, 9'h190};
    localparam int          MON_W   = 14;
    localparam logic [13:0] MON_MIN = 14'h000A;
    localparam logic [13:0] MON_MAX = 14'h2710;

    // Reset values.
    localparam logic [1:0]  RST_CH_EN     = 2'h3;
    localparam logic [1:0]  RST_WB_EN     = 2'h0;
    localparam logic [2:0]  RST_RB_CODE   = 3'h0;
    localparam logic        RST_CHAN_MODE = 1'b0;
    localparam logic [13:0] RST_MON       = 14'h0096;

endpackage

//--- ms_tick.sv
`timescale 1ns/10ps
`default_nettype none

module ms_tick
    import fs_pkg::*;
#(
    parameter int CYCLES = TICK_CYCLES
) (
    // Clock and reset.
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    // Millisecond enable.
    output logic      tick_out
);

    typedef struct packed {
        logic [15:0] cnt;
        logic        tick;
    } tick_state_s;

    tick_state_s s;
    tick_state_s next_s;

    // Free-running divider; the pulse lasts exactly one clock.
    always_comb begin
        next_s = s;
        next_s.tick = 1'b0;
        if (s.cnt == 16'(CYCLES - 1)) begin
            next_s.cnt = 16'h0000;
            next_s.tick = 1'b1;
        end else begin
            next_s.cnt = s.cnt + 16'h0001;
        end
    end

    // State register.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign tick_out = s.tick;

endmodule

`default_nettype wire

//--- readback_check.sv
`timescale 1ns/10ps
`default_nettype none

module readback_check
    import fs_pkg::*;
(
    // Clock and reset.
    input  wire logic               clk_in,
    input  wire logic               rst_n_in,
    // Time base and setting.
    input  wire logic               tick_in,
    input  wire logic [RB_MS_W-1:0] limit_in,
    // Channel state.
    input  wire logic               active_in,
    input  wire logic               cmd_in,
    input  wire logic               volt_in,
    // Fault pulses.
    output logic                    short_out,
    output logic                    disch_out
);

    typedef struct packed {
        logic               prev_cmd;
        logic               testing;
        logic [RB_MS_W-1:0] cnt;
        logic [RB_MS_W-1:0] integ;
        logic               short_f;
        logic               disch_f;
    } chk_state_s;

    chk_state_s s;
    chk_state_s next_s;
    logic       mismatch;

    // A turn-off test opens when the output falls; the voltage must be gone
    // before the readback time ends. Mismatches feed an up/down integrator,
    // so a symmetric disturbance whose half period stays within the limit never reaches it, while a static
    // short or a cross feed from the neighbour channel always does.
    always_comb begin
        next_s = s;
        next_s.short_f = 1'b0;
        next_s.disch_f = 1'b0;
        next_s.prev_cmd = cmd_in;
        mismatch = (cmd_in != volt_in) && !s.testing;
        if (!active_in) begin
            next_s.testing = 1'b0;
            next_s.cnt = '0;
            next_s.integ = '0;
        end else begin
            if (cmd_in) begin
                next_s.testing = 1'b0;
            end else if (s.prev_cmd) begin
                next_s.testing = 1'b1;
                next_s.cnt = '0;
            end else if (s.testing) begin
                if (!volt_in) begin
                    next_s.testing = 1'b0;
                end else if (tick_in) begin
                    // The first tick may come right after the edge, so the count
                    // must pass the limit: up to one extra millisecond is the
                    // price for never cutting the readback time short.
                    if (s.cnt >= limit_in) begin
                        next_s.disch_f = 1'b1;
                        next_s.testing = 1'b0;
                    end else begin
                        next_s.cnt = s.cnt + 9'h001;
                    end
                end
            end
            if (tick_in && mismatch) begin
                if (s.integ >= limit_in) begin
                    next_s.short_f = 1'b1;
                    next_s.integ = '0;
                end else begin
                    next_s.integ = s.integ + 9'h001;
                end
            end else if (tick_in && s.integ != '0) begin
                next_s.integ = s.integ - 9'h001;
            end
        end
    end

    // State register.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign short_out = s.short_f;
    assign disch_out = s.disch_f;

    a_short_limit: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        short_out |-> $past(tick_in) && ($past(s.integ) >= $past(limit_in)))
        else $error("short reported before readback time elapsed");

    a_discharge_limit: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        disch_out |-> $past(volt_in) && ($past(s.cnt) >= $past(limit_in)))
        else $error("discharge fault without elapsed readback time");

endmodule

`default_nettype wire

//--- failsafe_output_passivation.sv
// Implementation choices: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none

module failsafe_output_passivation
    import fs_pkg::*;
#(
    parameter int MS_CYCLES   = TICK_CYCLES,
    parameter int RECOVERY_MS = AUX_RECOVERY_MS
) (
    // Clock and reset.
    input  wire logic              sys_clk_in,
    input  wire logic              reset_n_in,
    // Register port.
    input  wire logic [ADDR_W-1:0] addr_in,
    input  wire logic [DATA_W-1:0] wr_data_in,
    input  wire logic              wr_en_in,
    input  wire logic              rd_en_in,
    output logic      [DATA_W-1:0] rd_data_out,
    // Field side.
    input  wire logic [NUM_CH-1:0] cmd_in,
    input  wire logic [NUM_CH-1:0] readback_in,
    input  wire logic [NUM_CH-1:0] load_present_in,
    input  wire logic              supply_ok_in,
    input  wire logic              aux_ok_in,
    // Outputs and indicators.
    output logic      [NUM_CH-1:0] do_out,
    output logic                   fault_indicator_out,
    output logic                   power_indicator_out
);

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    logic rst_meta;
    logic rst_sync_n;

    // Assertion is immediate, release is taken through two flops.
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rst_meta <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [NUM_CH-1:0]                ch_en;
        logic [NUM_CH-1:0]                wb_en;
        logic [NUM_CH-1:0][RB_CODE_W-1:0] rb_code;
        logic                             chan_mode;
        logic [MON_W-1:0]                 mon_time;
        logic [MON_W-1:0]                 wd_cnt;
        logic [NUM_CH-1:0]                ch_pass;
        logic                             mod_pass;
        logic [NUM_CH-1:0]                short_f;
        logic [NUM_CH-1:0]                disch_f;
        logic [NUM_CH-1:0]                wb_f;
        logic                             supply_loss;
        logic                             aux_fault;
        logic [15:0]                      recov;
        logic                             await_ack;
        logic                             param_err;
        logic                             comm_fault;
        logic [7:0]                       blink_cnt;
        logic                             blink_on;
        logic [NUM_CH-1:0]                do_o;
        logic                             fault_ind;
        logic                             power_ind;
        logic [DATA_W-1:0]                rd_data;
    } top_state_s;

    top_state_s                       s;
    top_state_s                       next_s;
    logic                             tick;
    logic [NUM_CH-1:0]                short_p;
    logic [NUM_CH-1:0]                disch_p;
    logic [NUM_CH-1:0][RB_MS_W-1:0]   rb_limit;
    logic                             ack_wr;
    logic                             other_err;
    logic [RB_CODE_W-1:0]             code0;
    logic [RB_CODE_W-1:0]             code1;
    logic [MON_W-1:0]                 mon_wr;

    // ------------------------------------------------------------------
    // Time base and per-channel checkers
    // ------------------------------------------------------------------
    ms_tick #(
        .CYCLES   (MS_CYCLES)
    ) u_tick (
        .clk_in   (sys_clk_in),
        .rst_n_in (rst_sync_n),
        .tick_out (tick)
    );

    for (genvar g = 0; g < NUM_CH; g++) begin : gen_ch
        // Each channel looks up its own readback time.
        assign rb_limit[g] = RB_MS_TABLE[s.rb_code[g]];

        readback_check u_chk (
            .clk_in    (sys_clk_in),
            .rst_n_in  (rst_sync_n),
            .tick_in   (tick),
            .limit_in  (rb_limit[g]),
            .active_in (s.ch_en[g] & ~s.ch_pass[g] & ~s.mod_pass),
            .cmd_in    (s.do_o[g]),
            .volt_in   (readback_in[g]),
            .short_out (short_p[g]),
            .disch_out (disch_p[g])
        );
    end

    // Decoded write fields.
    assign ack_wr = wr_en_in && (addr_in == REG_ACK) && wr_data_in[ACK_BIT];
    assign code0 = wr_data_in[CFG_RB_LSB +: RB_CODE_W];
    assign code1 = wr_data_in[CFG_RB_LSB + CFG_RB_STRIDE +: RB_CODE_W];
    assign mon_wr = wr_data_in[MON_W-1:0];

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    // Clears from an acknowledge come first so that any fault raised in
    // the same cycle overrides them and is never lost.
    always_comb begin
        next_s = s;
        other_err = 1'b0;

        // Acknowledge ends passivation only once the auxiliary fault has cleared after the recovery time.
        if (ack_wr && !s.aux_fault) begin
            next_s.ch_pass = '0;
            next_s.mod_pass = 1'b0;
            next_s.short_f = '0;
            next_s.disch_f = '0;
            next_s.wb_f = '0;
            next_s.supply_loss = 1'b0;
            next_s.param_err = 1'b0;
            next_s.comm_fault = 1'b0;
            next_s.await_ack = 1'b0;
        end

        // Any write is a life sign from the controller.
        if (wr_en_in) begin
            next_s.wd_cnt = '0;
        end

        // Static settings; an illegal value is refused whole and flagged.
        if (wr_en_in && addr_in == REG_CONFIG) begin
            if (code0 > RB_CODE_MAX || code1 > RB_CODE_MAX) begin
                next_s.param_err = 1'b1;
            end else begin
                next_s.ch_en = wr_data_in[CFG_EN_LSB +: NUM_CH];
                next_s.wb_en = wr_data_in[CFG_WB_LSB +: NUM_CH];
                next_s.rb_code[0] = code0;
                next_s.rb_code[1] = code1;
                next_s.chan_mode = wr_data_in[CFG_MODE_BIT];
            end
        end else if (wr_en_in && addr_in == REG_MONTIME) begin
            if (mon_wr < MON_MIN || mon_wr > MON_MAX) begin
                next_s.param_err = 1'b1;
            end else begin
                next_s.mon_time = mon_wr;
            end
        end

        // Monitoring time watchdog on controller traffic.
        if (tick && !wr_en_in) begin
            if (s.wd_cnt + 14'h0001 >= s.mon_time) begin
                next_s.comm_fault = 1'b1;
                next_s.mod_pass = 1'b1;
            end else begin
                next_s.wd_cnt = s.wd_cnt + 14'h0001;
            end
        end

        // Channel faults and wire break diagnostics.
        for (int i = 0; i < NUM_CH; i++) begin
            if (short_p[i]) begin
                next_s.short_f[i] = 1'b1;
            end
            if (disch_p[i]) begin
                next_s.disch_f[i] = 1'b1;
            end
            if (short_p[i] || disch_p[i]) begin
                if (s.chan_mode) begin
                    next_s.ch_pass[i] = 1'b1;
                end else begin
                    next_s.mod_pass = 1'b1;
                end
            end
            if (tick && s.wb_en[i] && s.do_o[i] && !load_present_in[i]) begin
                next_s.wb_f[i] = 1'b1;
            end
        end

        // Module supply loss: log and passivate all or the enabled channels.
        if (!supply_ok_in) begin
            next_s.supply_loss = 1'b1;
            if (s.chan_mode) begin
                next_s.ch_pass = next_s.ch_pass | s.ch_en;
            end else begin
                next_s.mod_pass = 1'b1;
            end
        end

        // Auxiliary dip restarts the recovery minute; any drop restarts it.
        if (!aux_ok_in) begin
            next_s.aux_fault = 1'b1;
            next_s.mod_pass = 1'b1;
            next_s.recov = 16'h0000;
        end else if (s.aux_fault && tick) begin
            if (s.recov == 16'(RECOVERY_MS - 1)) begin
                next_s.aux_fault = 1'b0;
                next_s.await_ack = 1'b1;
            end else begin
                next_s.recov = s.recov + 16'h0001;
            end
        end

        // Blink phase generator, slow enough to be read by eye.
        if (tick) begin
            if (s.blink_cnt == 8'(BLINK_HALF_MS - 1)) begin
                next_s.blink_cnt = 8'h00;
                next_s.blink_on = ~s.blink_on;
            end else begin
                next_s.blink_cnt = s.blink_cnt + 8'h01;
            end
        end

        // Indicators: steady on for live faults, blinking for a pending ack.
        other_err = |{next_s.short_f, next_s.disch_f, next_s.wb_f,
                      next_s.param_err, next_s.comm_fault};
        next_s.fault_ind = next_s.aux_fault || other_err ||
                           (next_s.await_ack && next_s.blink_on);
        next_s.power_ind = supply_ok_in;

        // Passivated or disabled channels are held off.
        next_s.do_o = cmd_in & next_s.ch_en & ~next_s.ch_pass &
                      {NUM_CH{~next_s.mod_pass}};

        // Read data stands in the cycle after the strobe only.
        next_s.rd_data = '0;
        if (rd_en_in) begin
            if (addr_in == REG_CONFIG) begin
                next_s.rd_data[CFG_EN_LSB +: NUM_CH] = s.ch_en;
                next_s.rd_data[CFG_WB_LSB +: NUM_CH] = s.wb_en;
                next_s.rd_data[CFG_RB_LSB +: RB_CODE_W] = s.rb_code[0];
                next_s.rd_data[CFG_RB_LSB + CFG_RB_STRIDE +: RB_CODE_W] = s.rb_code[1];
                next_s.rd_data[CFG_MODE_BIT] = s.chan_mode;
            end else if (addr_in == REG_MONTIME) begin
                next_s.rd_data[MON_W-1:0] = s.mon_time;
            end else if (addr_in == REG_STATUS) begin
                next_s.rd_data[ST_CH_PASS_LSB +: NUM_CH] = s.ch_pass;
                next_s.rd_data[ST_MOD_PASS] = s.mod_pass;
                next_s.rd_data[ST_SHORT_LSB +: NUM_CH] = s.short_f;
                next_s.rd_data[ST_DISCH_LSB +: NUM_CH] = s.disch_f;
                next_s.rd_data[ST_WB_LSB +: NUM_CH] = s.wb_f;
                next_s.rd_data[ST_SUPPLY] = s.supply_loss;
                next_s.rd_data[ST_AUX] = s.aux_fault;
                next_s.rd_data[ST_AWAIT] = s.await_ack;
                next_s.rd_data[ST_PARAM] = s.param_err;
                next_s.rd_data[ST_COMM] = s.comm_fault;
            end
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_in or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            s <= '0;
            s.ch_en <= RST_CH_EN;
            s.wb_en <= RST_WB_EN;
            s.rb_code <= {NUM_CH{RST_RB_CODE}};
            s.chan_mode <= RST_CHAN_MODE;
            s.mon_time <= RST_MON;
        end else begin
            s <= next_s;
        end
    end

    assign rd_data_out = s.rd_data;
    assign do_out = s.do_o;
    assign fault_indicator_out = s.fault_ind;
    assign power_indicator_out = s.power_ind;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_output_gated: assert property (@(posedge sys_clk_in) disable iff (!rst_sync_n)
        s.mod_pass && !ack_wr |=> do_out == '0)
        else $error("output driven while module passivated");

    a_aux_passivate: assert property (@(posedge sys_clk_in) disable iff (!rst_sync_n)
        !aux_ok_in |=> s.mod_pass && fault_indicator_out && do_out == '0)
        else $error("auxiliary dip did not passivate module");

    a_power_off: assert property (@(posedge sys_clk_in) disable iff (!rst_sync_n)
        !supply_ok_in |=> !power_indicator_out && s.supply_loss)
        else $error("supply loss not shown");

    a_whole_default: assert property (@(posedge sys_clk_in) disable iff (!rst_sync_n)
        !s.chan_mode && (short_p != '0 || disch_p != '0) |=> s.mod_pass)
        else $error("channel fault did not passivate module");

    a_chan_only: assert property (@(posedge sys_clk_in) disable iff (!rst_sync_n)
        s.chan_mode && short_p[0] |=> s.ch_pass[0])
        else $error("channel fault did not passivate channel");

    a_await_hold: assert property (@(posedge sys_clk_in) disable iff (!rst_sync_n)
        s.await_ack && !ack_wr |=> s.await_ack)
        else $error("pending acknowledge ended without acknowledge");

    a_aux_stays: assert property (@(posedge sys_clk_in) disable iff (!rst_sync_n)
        $fell(s.aux_fault) |-> s.mod_pass && s.await_ack &&
            $past(s.recov) == RECOVERY_MS - 1)
        else $error("auxiliary recovery timing or passivation wrong");

    a_montime_range: assert property (@(posedge sys_clk_in) disable iff (!rst_sync_n)
        s.mon_time >= MON_MIN && s.mon_time <= MON_MAX)
        else $error("monitoring time out of range");

    a_rb_code: assert property (@(posedge sys_clk_in) disable iff (!rst_sync_n)
        s.rb_code[0] <= RB_CODE_MAX && s.rb_code[1] <= RB_CODE_MAX)
        else $error("readback code outside allowed set");

endmodule

`default_nettype wire

//--- fs_controller_model.sv
`timescale 1ns/10ps
`default_nettype none
// Safety controller: owns the register strobes and sets static parameters.
module fs_controller_model
    import fs_pkg::*;
(
    // Clock and read data.
    input  wire logic              clk_in,
    input  wire logic [DATA_W-1:0] rd_data_in,
    // Register strobes.
    output logic      [ADDR_W-1:0] addr_out,
    output logic      [DATA_W-1:0] wr_data_out,
    output logic                   wr_en_out,
    output logic                   rd_en_out
);
    initial begin
        addr_out = 4'h0;
        wr_data_out = 16'h0000;
        wr_en_out = 1'b0;
        rd_en_out = 1'b0;
    end
    // Released data is inverted so stale values never look valid.
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_in);
        addr_out <= a;
        wr_data_out <= d;
        wr_en_out <= 1'b1;
        @(posedge clk_in);
        wr_en_out <= 1'b0;
        wr_data_out <= ~d;
    endtask
    // Read data stand only in the cycle after the strobe.
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk_in);
        addr_out <= a;
        rd_en_out <= 1'b1;
        @(posedge clk_in);
        rd_en_out <= 1'b0;
        #1 d = rd_data_in;
    endtask
    // Acknowledge is the only way out of the awaiting state.
    task automatic ack();
        wr(REG_ACK, 16'h0001);
    endtask
endmodule
`default_nettype wire

//--- failsafe_output_passivation_test.sv
`timescale 1ns/10ps
`default_nettype none
module failsafe_output_passivation_test
    import fs_pkg::*;
;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [15:0] rdat;
    logic [3:0]  addr;
    logic [15:0] wdat;
    logic        wr;
    logic        rd;
    logic [1:0]  cmd = 2'h0;
    logic [1:0]  inj = 2'h0;
    logic [1:0]  brk = 2'h0;
    logic        blink;
    logic        sup = 1'b1;
    logic        aux = 1'b1;
    logic [1:0]  dout;
    logic        fi;
    logic        pi;
    int          error_cnt = 0;
    int          checked = 0;
    // Healthy loads echo the outputs; inj inverts the echoed voltage, so a driven output reads as missing and an off output as stuck.
    wire  [1:0]  rbk = dout ^ inj;
    always #25 clk = ~clk;
    fs_controller_model ctl (.clk_in(clk), .rd_data_in(rdat), .addr_out(addr),
        .wr_data_out(wdat), .wr_en_out(wr), .rd_en_out(rd));
    failsafe_output_passivation #(.MS_CYCLES(10), .RECOVERY_MS(5)) dut (
        .sys_clk_in(clk), .reset_n_in(rst_n), .addr_in(addr), .wr_data_in(wdat),
        .wr_en_in(wr), .rd_en_in(rd), .rd_data_out(rdat), .cmd_in(cmd),
        .readback_in(rbk), .load_present_in(dout & ~brk), .supply_ok_in(sup),
        .aux_ok_in(aux), .do_out(dout), .fault_indicator_out(fi),
        .power_indicator_out(pi));
    task automatic chk(input logic [15:0] g, input logic [15:0] e, input logic [15:0] m);
        checked++;
        if ((g & m) !== e) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic rchk(input logic [3:0] a, input logic [15:0] e, input logic [15:0] m);
        logic [15:0] d;
        ctl.rd(a, d);
        chk(d, e, m);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // A hang is cut short well beyond the expected run time.
    initial begin
        #1_000_000;
        error_cnt++;
        wrap_up();
    end
    initial begin
        cyc(5);
        rst_n <= 1'b1;
        cyc(4);
        rchk(REG_CONFIG, 16'h0003, 16'h1FFF);
        rchk(REG_MONTIME, 16'h0096, 16'h3FFF);
        ctl.wr(REG_MONTIME, 16'h2710);
        ctl.wr(REG_CONFIG, 16'h0073);
        rchk(REG_CONFIG, 16'h0003, 16'h1FFF);
        rchk(REG_STATUS, 16'h1000, 16'h1000);
        ctl.wr(REG_MONTIME, 16'h0009);
        rchk(REG_MONTIME, 16'h2710, 16'h3FFF);
        ctl.ack();
        cmd <= 2'h3;
        cyc(3);
        chk(dout, 16'h3, 16'h3);
        $display("config test done");
        inj <= 2'h1;
        cyc(10);
        chk(dout, 16'h3, 16'h3);
        cyc(53);
        chk(dout, 16'h0, 16'h3);
        rchk(REG_STATUS, 16'h000C, 16'h001C);
        inj <= 2'h0;
        ctl.ack();
        cyc(3);
        chk(dout, 16'h3, 16'h3);
        ctl.wr(REG_CONFIG, 16'h1003);
        inj <= 2'h2;
        cyc(60);
        chk(dout, 16'h1, 16'h3);
        inj <= 2'h0;
        ctl.ack();
        cmd <= 2'h1;
        inj <= 2'h2;
        cyc(60);
        rchk(REG_STATUS, 16'h0040, 16'h0040);
        inj <= 2'h0;
        cmd <= 2'h3;
        ctl.wr(REG_CONFIG, 16'h1033);
        ctl.ack();
        $display("short test done");
        // A 125 Hz symmetric disturbance must not trip a 50 ms channel.
        repeat (10) begin
            inj <= 2'h1;
            cyc(40);
            inj <= 2'h0;
            cyc(40);
        end
        chk(dout, 16'h3, 16'h3);
        inj <= 2'h1;
        cyc(480);
        chk(dout, 16'h3, 16'h3);
        cyc(40);
        chk(dout, 16'h2, 16'h3);
        inj <= 2'h0;
        ctl.ack();
        $display("filter test done");
        aux <= 1'b0;
        cyc(2);
        chk(fi, 16'h1, 16'h1);
        chk(dout, 16'h0, 16'h3);
        aux <= 1'b1;
        cyc(20);
        chk(fi, 16'h1, 16'h1);
        cyc(60);
        rchk(REG_STATUS, 16'h0804, 16'h0C04);
        chk(dout, 16'h0, 16'h3);
        // One half period of the blink is exactly 250 ticks.
        blink = fi;
        cyc(2500);
        chk(fi, {15'h0000, ~blink}, 16'h0001);
        ctl.ack();
        cyc(3);
        chk(dout, 16'h3, 16'h3);
        rchk(REG_STATUS, 16'h0000, 16'h0804);
        sup <= 1'b0;
        cyc(2);
        chk(pi, 16'h0, 16'h1);
        chk(dout, 16'h0, 16'h3);
        sup <= 1'b1;
        cyc(2);
        rchk(REG_STATUS, 16'h0200, 16'h0200);
        $display("supply test done");
        ctl.wr(REG_CONFIG, 16'h1037);
        ctl.ack();
        brk <= 2'h1;
        cyc(12);
        rchk(REG_STATUS, 16'h0080, 16'h0180);
        chk(fi, 16'h1, 16'h1);
        rst_n <= 1'b0;
        cyc(2);
        chk(dout, 16'h0, 16'h3);
        rst_n <= 1'b1;
        cyc(4);
        rchk(REG_CONFIG, 16'h0003, 16'h1FFF);
        rchk(REG_STATUS, 16'h0000, 16'h3FFF);
        $display("reset test done");
        wrap_up();
    end
endmodule
`default_nettype wire
